/* File: hw/ssp_defs.svh */
// Constants for the system clock select and prescaler block.
// Assumes a 10 MHz core clock and Avalon-MM byte addresses.
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// ==========================================================
// Clock and timing
`define SSP_CORE_CLK_HZ      10000000
`define SSP_LP_OSC_HZ        128000
`define SSP_LP_OSC_DIV       (`SSP_CORE_CLK_HZ / `SSP_LP_OSC_HZ)
`define SSP_WAKE_CK          6
`define SSP_RESET_CK         14
`define SSP_LP_SHORT_US      4000
`define SSP_LP_LONG_US       64000
`define SSP_STD_SHORT_US     4100
`define SSP_STD_LONG_US      65000
`define SSP_US_TO_CYC(us)    ((us) * (`SSP_CORE_CLK_HZ / 1000000))
`define SSP_PCE_WINDOW       4
`define SSP_STRAP_SETTLE     3

// ==========================================================
// Register map (byte addresses, one 32-bit word each)
`define SSP_PRESCALE_INDEX   10'h061
`define SSP_PRESCALE_ADDR    (`SSP_PRESCALE_INDEX * 4)
`define SSP_STATUS_ADDR      10'h000
`define SSP_ASYNC_ADDR       10'h004

// ==========================================================
// Field layout and values
`define SSP_PCE_BIT          7
`define SSP_PCE_ARM_VAL      8'h80
`define SSP_PS_MAX           4'h8
`define SSP_PS_RESET         4'h0
`define SSP_PS_DIV8          4'h3
`define SSP_SRC_EXT          4'h0
`define SSP_SRC_RC           4'h2
`define SSP_SRC_LP           4'h3
`define SSP_STARTUP_SHORT    2'h1
`define SSP_STARTUP_LONG     2'h2

`endif

/* File: hw/ssp_pkg.sv */
// Types shared by the clock select and prescaler files.
// Assumes nothing beyond a SystemVerilog compiler.
package ssp_pkg;

  // ========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    SSP_INIT   = 3'b000,
    SSP_RST_CK = 3'b001,
    SSP_RST_MS = 3'b010,
    SSP_RUN    = 3'b011,
    SSP_SLEEP  = 3'b100,
    SSP_WAKE   = 3'b101
  } ssp_state_type;

  // ========================================================
  // Clock source kinds
  typedef enum logic [1:0] {
    SSP_CLK_RC  = 2'b00,
    SSP_CLK_EXT = 2'b01,
    SSP_CLK_LP  = 2'b10
  } ssp_source_type;

endpackage

/* File: hw/ssp_ripple_stage.sv */
// One stage of the prescaler ripple counter.
// Assumes the stage below hands over its carry in the same cycle.
`timescale 1ns/1ps
module ssp_ripple_stage (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic carry_in,
  output logic      bit_q,
  output logic      carry_out
);

  logic bit_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bit_reg <= 1'b0;
    end else if (carry_in) begin
      bit_reg <= ~bit_reg;
    end
  end

  assign bit_q     = bit_reg;
  assign carry_out = carry_in & bit_reg;

endmodule // ssp_ripple_stage

/* File: hw/ssp_clock_ctrl.sv */
// Clock source select, start-up delay, clock output and prescaler.
// Assumes settings arrive as static straps, the external and timer
// oscillator pins are sampled on core_clk, and software uses Avalon-MM.
`timescale 1ns/1ps
`include "ssp_defs.svh"
module ssp_clock_ctrl #(
  parameter int unsigned LP_SHORT_CYC  = `SSP_US_TO_CYC(`SSP_LP_SHORT_US),
  parameter int unsigned LP_LONG_CYC   = `SSP_US_TO_CYC(`SSP_LP_LONG_US),
  parameter int unsigned STD_SHORT_CYC = `SSP_US_TO_CYC(`SSP_STD_SHORT_US),
  parameter int unsigned STD_LONG_CYC  = `SSP_US_TO_CYC(`SSP_STD_LONG_US),
  parameter int unsigned CNT_STAGES    = 8
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [3:0]  clock_source_select_setting,
  input  wire logic [1:0]  startup_time_setting,
  input  wire logic        clock_output_setting,
  input  wire logic        divide_by_eight_setting,
  input  wire logic        external_clock_input,
  input  wire logic        timer_osc_pin_one,
  input  wire logic        sleep_request,
  output logic             cpu_clock_domain_en,
  output logic             io_clock_domain_en,
  output logic             flash_clock_domain_en,
  output logic             timer_clock_en,
  output logic             clock_output_pin_o,
  output logic             clock_output_pin_oe,
  output logic             sys_reset_active
);
  import ssp_pkg::*;

  // ========================================================
  // Pin synchronisers
  logic [1:0] ext_sync_reg;
  logic [1:0] tosc_sync_reg;
  logic       ext_prev_reg;
  logic       tosc_prev_reg;
  logic [7:0] strap_meta_reg;
  logic [7:0] strap_sync_reg;
  wire  [7:0] strap_pins = {divide_by_eight_setting, clock_output_setting,
                            startup_time_setting,
                            clock_source_select_setting};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_sync_reg   <= 2'h0;
      tosc_sync_reg  <= 2'h0;
      ext_prev_reg   <= 1'b0;
      tosc_prev_reg  <= 1'b0;
      strap_meta_reg <= 8'h00;
      strap_sync_reg <= 8'h00;
    end else begin
      ext_sync_reg   <= {ext_sync_reg[0], external_clock_input};
      tosc_sync_reg  <= {tosc_sync_reg[0], timer_osc_pin_one};
      ext_prev_reg   <= ext_sync_reg[1];
      tosc_prev_reg  <= tosc_sync_reg[1];
      strap_meta_reg <= strap_pins;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  wire ext_rise  = ext_sync_reg[1] & ~ext_prev_reg;
  wire tosc_rise = tosc_sync_reg[1] & ~tosc_prev_reg;

  // ========================================================
  // Settings captured once after reset release
  ssp_state_type state_reg;
  ssp_state_type state_next;
  logic [3:0]    src_sel_reg;
  logic [1:0]    startup_reg;
  logic          clk_out_reg;
  logic          div8_reg;
  logic [1:0]    settle_reg;
  wire           capture = (state_reg == SSP_INIT) &&
                           (settle_reg == 2'(`SSP_STRAP_SETTLE - 1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      settle_reg <= 2'h0;
      src_sel_reg <= 4'h0;
      startup_reg <= 2'h0;
      clk_out_reg <= 1'b0;
      div8_reg   <= 1'b0;
    end else if (state_reg == SSP_INIT) begin
      settle_reg <= settle_reg + 2'h1;
      if (capture) begin
        src_sel_reg <= strap_sync_reg[3:0];
        startup_reg <= strap_sync_reg[5:4];
        clk_out_reg <= strap_sync_reg[6];
        div8_reg  <= strap_sync_reg[7];
      end
    end
  end

  // Unlisted codes fall back to the calibrated RC source
  wire ssp_source_type source =
    (src_sel_reg == `SSP_SRC_LP)  ? SSP_CLK_LP :
    (src_sel_reg == `SSP_SRC_EXT) ? SSP_CLK_EXT :
    SSP_CLK_RC;

  // ========================================================
  // Source clock ticks on the core clock
  localparam int unsigned LP_DIV = `SSP_LP_OSC_DIV;
  logic [6:0] lp_cnt_reg;
  wire        lp_tick = (lp_cnt_reg == 7'(LP_DIV - 1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lp_cnt_reg <= 7'h00;
    end else if (lp_tick) begin
      lp_cnt_reg <= 7'h00;
    end else begin
      lp_cnt_reg <= lp_cnt_reg + 7'h01;
    end
  end

  // External pin is trusted to change slowly between cycles
  wire src_tick = (source == SSP_CLK_LP)  ? lp_tick :
                  (source == SSP_CLK_EXT) ? ext_rise :
                  1'b1;

  // ========================================================
  // Ripple prescaler counter, not visible to software
  logic [CNT_STAGES:0]   carry;
  logic [CNT_STAGES-1:0] cnt_bits;
  assign carry[0] = src_tick;

  genvar g;
  generate
    for (g = 0; g < CNT_STAGES; g++) begin : g_stage
      ssp_ripple_stage u_stage (
        .core_clk  (core_clk),
        .rst       (rst),
        .carry_in  (carry[g]),
        .bit_q     (cnt_bits[g]),
        .carry_out (carry[g+1])
      );
    end
  endgenerate

  logic [3:0] ps_reg;
  logic [3:0] ps_active_reg;
  logic       pend_reg;
  wire  [CNT_STAGES-1:0] div_mask =
    ~({CNT_STAGES{1'b1}} << ps_active_reg);
  wire div_done = src_tick & ((cnt_bits & div_mask) == div_mask);

  // Switch only at the end of an old period, so the counter bits under the old mask wrap
  // to zero and a first new period at a ratio no larger than the old is whole
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ps_active_reg <= `SSP_PS_RESET;
    end else if (capture) begin
      ps_active_reg <= strap_sync_reg[7] ? `SSP_PS_DIV8
                                         : `SSP_PS_RESET;
    end else if (pend_reg && div_done) begin
      ps_active_reg <= ps_reg;
    end
  end

  // ========================================================
  // Start-up and wake sequencer
  logic [19:0] tmr_reg;
  logic [19:0] tmr_next;
  logic [19:0] ms_cyc;

  always_comb begin
    ms_cyc = 20'h00000;
    if (startup_reg == `SSP_STARTUP_SHORT) begin
      ms_cyc = (source == SSP_CLK_LP) ? 20'(LP_SHORT_CYC)
                                      : 20'(STD_SHORT_CYC);
    end else if (startup_reg == `SSP_STARTUP_LONG) begin
      ms_cyc = (source == SSP_CLK_LP) ? 20'(LP_LONG_CYC)
                                      : 20'(STD_LONG_CYC);
    end
  end

  always_comb begin
    state_next = state_reg;
    tmr_next   = tmr_reg;
    case (state_reg)
      SSP_INIT: begin
        if (capture) begin
          state_next = SSP_RST_CK;
          tmr_next   = 20'(`SSP_RESET_CK);
        end
      end
      SSP_RST_CK: begin
        if (src_tick) begin
          tmr_next = tmr_reg - 20'h1;
          if (tmr_reg == 20'h1) begin
            state_next = (ms_cyc == 20'h0) ? SSP_RUN : SSP_RST_MS;
            tmr_next   = ms_cyc;
          end
        end
      end
      SSP_RST_MS: begin
        tmr_next = tmr_reg - 20'h1;
        if (tmr_reg == 20'h1) begin
          state_next = SSP_RUN;
        end
      end
      SSP_RUN: begin
        if (sleep_request) begin
          state_next = SSP_SLEEP;
        end
      end
      SSP_SLEEP: begin
        if (!sleep_request) begin
          state_next = SSP_WAKE;
          tmr_next   = 20'(`SSP_WAKE_CK);
        end
      end
      SSP_WAKE: begin
        if (src_tick) begin
          tmr_next = tmr_reg - 20'h1;
          if (tmr_reg == 20'h1) begin
            state_next = SSP_RUN;
          end
        end
      end
      default: begin
        state_next = SSP_INIT;
      end
    endcase
  end

  logic rst_act_reg;
  wire  rst_act_next = (state_next == SSP_INIT) ||
                       (state_next == SSP_RST_CK) ||
                       (state_next == SSP_RST_MS);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg   <= SSP_INIT;
      tmr_reg     <= 20'h00000;
      rst_act_reg <= 1'b1;
    end else begin
      state_reg   <= state_next;
      tmr_reg     <= tmr_next;
      rst_act_reg <= rst_act_next;
    end
  end

  wire in_reset = (state_reg == SSP_INIT) || (state_reg == SSP_RST_CK) ||
                  (state_reg == SSP_RST_MS);
  wire running  = (state_reg == SSP_RUN);

  // ========================================================
  // Avalon-MM slave, one wait state per access
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic        pce_reg;
  logic [1:0]  win_reg;
  logic        async_en_reg;

  wire        req_take = (avs_read | avs_write) & wait_reg;
  wire        hit_pr   = (avs_address == 10'(`SSP_PRESCALE_ADDR));
  wire        hit_st   = (avs_address == `SSP_STATUS_ADDR);
  wire        hit_as   = (avs_address == `SSP_ASYNC_ADDR);
  wire        wr_lane0 = req_take & avs_write & avs_byteenable[0];
  wire [7:0]  wbyte    = avs_writedata[7:0];
  wire        wr_pr    = wr_lane0 & hit_pr;
  wire        arm_wr   = wr_pr & (wbyte == `SSP_PCE_ARM_VAL);
  wire        sel_wr   = wr_pr & ~wbyte[`SSP_PCE_BIT] & pce_reg;
  wire        sel_ok   = (wbyte[3:0] <= `SSP_PS_MAX);
  wire [31:0] rd_pr    = {24'h0, pce_reg, 3'h0, ps_reg};
  wire [31:0] rd_st    = {18'h0, ps_active_reg, ~running, in_reset,
                          div8_reg, clk_out_reg, startup_reg, src_sel_reg};
  wire [31:0] rd_as    = {31'h0, async_en_reg};
  wire [31:0] rd_mux   = hit_pr ? rd_pr : hit_st ? rd_st :
                         hit_as ? rd_as : 32'h0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0;
    end else begin
      wait_reg <= ~req_take;
      if (req_take && avs_read) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // ========================================================
  // Timed prescale change sequence
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pce_reg <= 1'b0;
      win_reg <= 2'h0;
    end else if (sel_wr) begin
      pce_reg <= 1'b0;
    end else if (arm_wr && !pce_reg) begin
      pce_reg <= 1'b1;
      win_reg <= 2'(`SSP_PCE_WINDOW - 1);
    end else if (pce_reg) begin
      if (win_reg == 2'h0) begin
        pce_reg <= 1'b0;
      end else begin
        win_reg <= win_reg - 2'h1;
      end
    end
  end

  // Reserved codes are dropped and the window still closes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ps_reg   <= `SSP_PS_RESET;
      pend_reg <= 1'b0;
    end else if (capture) begin
      ps_reg <= strap_sync_reg[7] ? `SSP_PS_DIV8 : `SSP_PS_RESET;
    end else if (sel_wr && sel_ok) begin
      ps_reg   <= wbyte[3:0];
      pend_reg <= 1'b1;
    end else if (pend_reg && div_done) begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      async_en_reg <= 1'b0;
    end else if (wr_lane0 && hit_as) begin
      async_en_reg <= avs_writedata[0];
    end
  end

  // ========================================================
  // Clock enables and clock output pin
  logic cpu_en_reg;
  logic io_en_reg;
  logic flash_en_reg;
  logic tmr_en_reg;
  logic pin_clk_reg;
  logic pin_oe_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_en_reg   <= 1'b0;
      io_en_reg    <= 1'b0;
      flash_en_reg <= 1'b0;
      tmr_en_reg   <= 1'b0;
      pin_clk_reg  <= 1'b0;
      pin_oe_reg   <= 1'b0;
    end else begin
      cpu_en_reg   <= running & div_done;
      io_en_reg    <= running & div_done;
      flash_en_reg <= running & div_done;
      tmr_en_reg   <= async_en_reg & tosc_rise &
                      (source == SSP_CLK_RC);
      pin_clk_reg  <= clk_out_reg & div_done;
      pin_oe_reg   <= clk_out_reg;
    end
  end

  assign avs_waitrequest       = wait_reg;
  assign avs_readdata          = rdata_reg;
  assign cpu_clock_domain_en   = cpu_en_reg;
  assign io_clock_domain_en    = io_en_reg;
  assign flash_clock_domain_en = flash_en_reg;
  assign timer_clock_en        = tmr_en_reg;
  assign clock_output_pin_o    = pin_clk_reg;
  assign clock_output_pin_oe   = pin_oe_reg;
  assign sys_reset_active      = rst_act_reg;

endmodule // ssp_clock_ctrl

/* File: bench/ssp_clock_ctrl_chk.sv */
// Concurrent checks on the clock select and prescaler top ports.
// Assumes binding to ssp_clock_ctrl with one core clock domain.
`timescale 1ns/1ps
module ssp_clock_ctrl_chk (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [3:0]  clock_source_select_setting,
  input wire logic [1:0]  startup_time_setting,
  input wire logic        clock_output_setting,
  input wire logic        divide_by_eight_setting,
  input wire logic        external_clock_input,
  input wire logic        timer_osc_pin_one,
  input wire logic        sleep_request,
  input wire logic        cpu_clock_domain_en,
  input wire logic        io_clock_domain_en,
  input wire logic        flash_clock_domain_en,
  input wire logic        timer_clock_en,
  input wire logic        clock_output_pin_o,
  input wire logic        clock_output_pin_oe,
  input wire logic        sys_reset_active
);
  // ========================================================
  // Helper: edges since reset release
  logic [7:0] rel_cnt_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) rel_cnt_reg <= 8'h00;
    else if (rel_cnt_reg != 8'hFF) rel_cnt_reg <= rel_cnt_reg + 8'h01;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ========================================================
  // Assertions
  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  a_answer_stands: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_domains_equal: assert property (
    cpu_clock_domain_en == io_clock_domain_en &&
    io_clock_domain_en == flash_clock_domain_en)
    else $error("clock domain enables differ");
  a_pin_follows_cpu: assert property (
    clock_output_pin_oe && cpu_clock_domain_en |-> clock_output_pin_o)
    else $error("clock output pin differs from divided clock");
  a_pin_in_reset: assert property (
    clock_output_pin_oe && sys_reset_active |->
    ##[0:700] clock_output_pin_o)
    else $error("clock output pin quiet while held in reset");
  a_oe_from_setting: assert property (
    clock_output_pin_oe |-> clock_output_setting)
    else $error("clock output enabled without setting");
  a_held_quiet: assert property (
    sys_reset_active |-> !cpu_clock_domain_en && !timer_clock_en)
    else $error("clock enable while held in reset");
  a_timer_rc_only: assert property (
    timer_clock_en |-> clock_source_select_setting == 4'h2)
    else $error("timer clock without calibrated source");
  a_sleep_stops: assert property (
    sleep_request [*3] |-> !cpu_clock_domain_en)
    else $error("clock enable during deep sleep");
  a_wake_delay: assert property (
    $fell(sleep_request) |-> !cpu_clock_domain_en [*5])
    else $error("wake from sleep too early");
  a_reset_delay: assert property (
    $fell(sys_reset_active) |-> rel_cnt_reg >= 8'h0E)
    else $error("reset released before start-up delay");
endmodule // ssp_clock_ctrl_chk

/* File: bench/ssp_clock_ctrl_tb.sv */
// Self-checking bench for the clock select and prescaler block.
// Starts on the calibrated source strap, so one source tick per cycle, then reruns on the LP and external sources.
`timescale 1ns/1ps
`include "ssp_defs.svh"
module ssp_clock_ctrl_tb;
  import ssp_pkg::*;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %h want %h", $time, a, b); end end

  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  clock_source_select_setting = 4'h2;
  logic [1:0]  startup_time_setting = 2'h0;
  logic        clock_output_setting = 1'b1;
  logic        divide_by_eight_setting = 1'b1;
  logic        external_clock_input = 1'b0;
  logic        timer_osc_pin_one = 1'b0;
  logic        sleep_request = 1'b0;
  logic        ext_run = 1'b0;
  logic        cpu_clock_domain_en, io_clock_domain_en;
  logic        flash_clock_domain_en, timer_clock_en;
  logic        clock_output_pin_o, clock_output_pin_oe, sys_reset_active;
  logic [31:0] rd;
  int          errors = 0;
  int          comparisons = 0;
  int          g, n;
  localparam logic [9:0] PS = 10'(`SSP_PRESCALE_ADDR);
  localparam logic [9:0] ST = `SSP_STATUS_ADDR;
  localparam logic [9:0] AS = `SSP_ASYNC_ADDR;

  always #50 core_clk = ~core_clk;

  // Steady external clock at half the core rate, held low in reset
  always @(posedge core_clk)
    external_clock_input <= ext_run && !rst && !external_clock_input;

  ssp_clock_ctrl #(.LP_SHORT_CYC(20), .LP_LONG_CYC(40),
    .STD_SHORT_CYC(20), .STD_LONG_CYC(40)) dut (.*);

  // ========================================================
  // Tasks
  task summarize;
    $display("Mismatches %0d, comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task fail_wait;
    errors++;
    $display("Error at %0t: wait limit reached", $time);
    summarize;
  endtask

  task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    i = 0;
    do begin
      @(posedge core_clk);
      #1;
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    if (avs_waitrequest !== 1'b0) fail_wait;
    @(posedge core_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rdchk(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  task set_div(input logic [31:0] d);
    wr(PS, 32'h80);
    wr(PS, d);
  endtask

  task gap(output int c);
    int i;
    i = 0;
    c = 0;
    do begin
      @(posedge core_clk);
      #1;
      i++;
    end while (cpu_clock_domain_en !== 1'b1 && i < 700);
    do begin
      @(posedge core_clk);
      #1;
      c++;
    end while (cpu_clock_domain_en !== 1'b1 && c < 700);
    if (i >= 700 || c >= 700) fail_wait;
  endtask

  task expect_gap(input int e);
    gap(g);
    gap(g);
    `CHK(g, e)
  endtask

  task expect_div(input int k);
    expect_gap(1 << k);
  endtask

  task timer_pulses(output int c);
    c = 0;
    repeat (10) begin
      @(posedge core_clk);
      timer_osc_pin_one <= ~timer_osc_pin_one;
      repeat (4) begin
        @(posedge core_clk);
        #1;
        if (timer_clock_en === 1'b1) c++;
      end
    end
  endtask

  task reset_run(output int c);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    c = 0;
    do begin
      @(posedge core_clk);
      #1;
      c++;
    end while (sys_reset_active !== 1'b0 && c < 1500);
    if (sys_reset_active !== 1'b0) fail_wait;
  endtask

  // ========================================================
  // Main sequence
  initial begin
    reset_run(n);
    `CHK(n, `SSP_STRAP_SETTLE + `SSP_RESET_CK)
    `CHK(clock_output_pin_oe, 1'b1)
    rdchk(ST, 32'h0000_0CC2);
    rdchk(PS, 32'h3);
    expect_div(3);
    for (int k = 0; k <= 8; k++) begin
      set_div(32'(k));
      rdchk(PS, 32'(k));
      expect_div(k);
    end
    set_div(32'h1);
    wr(PS, 32'h80);
    wr(PS, 32'h9);
    rdchk(PS, 32'h1);
    wr(PS, 32'h5);
    rdchk(PS, 32'h1);
    expect_div(1);
    wr(PS, 32'h83);
    wr(PS, 32'h4);
    rdchk(PS, 32'h1);
    wr(PS, 32'h80);
    rdchk(PS, 32'h81);
    rdchk(PS, 32'h1);
    wr(PS, 32'h4);
    rdchk(PS, 32'h1);
    wr(PS, 32'h80);
    wr(PS, 32'h80);
    rdchk(PS, 32'h1);
    set_div(32'h2);
    rdchk(PS, 32'h2);
    @(posedge core_clk);
    avs_byteenable <= 4'h0;
    set_div(32'h5);
    avs_byteenable <= 4'hF;
    rdchk(PS, 32'h2);
    wr(10'h010, 32'hFF);
    rdchk(10'h010, 32'h0);
    timer_pulses(n);
    `CHK(n, 0)
    wr(AS, 32'h1);
    rdchk(AS, 32'h1);
    timer_pulses(n);
    `CHK(n, 5)
    @(posedge core_clk);
    sleep_request <= 1'b1;
    repeat (4) @(posedge core_clk);
    n = 0;
    repeat (20) begin
      @(posedge core_clk);
      #1;
      if (cpu_clock_domain_en === 1'b1) n++;
    end
    `CHK(n, 0)
    @(posedge core_clk);
    sleep_request <= 1'b0;
    expect_div(2);
    @(posedge core_clk);
    divide_by_eight_setting <= 1'b0;
    reset_run(n);
    rdchk(PS, 32'h0);
    expect_div(0);
    @(posedge core_clk);
    clock_source_select_setting <= `SSP_SRC_LP;
    startup_time_setting <= `SSP_STARTUP_SHORT;
    reset_run(n);
    `CHK(n, `SSP_RESET_CK * `SSP_LP_OSC_DIV + 20)
    rdchk(ST, 32'h0000_0053);
    expect_gap(`SSP_LP_OSC_DIV);
    @(posedge core_clk);
    clock_source_select_setting <= `SSP_SRC_EXT;
    ext_run <= 1'b1;
    reset_run(n);
    `CHK(n, 2 * `SSP_RESET_CK + 22)
    rdchk(ST, 32'h0000_0050);
    expect_gap(2);
    summarize;
  end
endmodule // ssp_clock_ctrl_tb

bind ssp_clock_ctrl ssp_clock_ctrl_chk chk (.*);
